/* rtl/ldo_channel_control.sv */
// Control logic for four linear regulator channels
`timescale 1ns/1ps
module ldo_channel_control #(
	parameter int DELAY_UNIT_CYCLES = ldo_pkg::DELAY_UNIT_CYC
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire ldo_pkg::ldo_ctrl_t [ldo_pkg::NUM_CH-1:0] ctrl,
	input wire logic [ldo_pkg::NUM_CH-1:0] code_write,
	input wire logic [ldo_pkg::CODE_W-1:0] code_wdata,
	input wire logic [ldo_pkg::NUM_CH-1:0] pg_read,
	input wire logic [ldo_pkg::NUM_CH-1:0] out_above_threshold,
	output ldo_pkg::ldo_drive_t [ldo_pkg::NUM_CH-1:0] drive,
	output logic [ldo_pkg::NUM_CH-1:0] power_good_flag,
	output logic [ldo_pkg::NUM_CH-1:0] channel_on,
	output logic interrupt_request_n
);

	// ------------------------------------------------------------
	// Elaboration checks
	// ------------------------------------------------------------
	if (DELAY_UNIT_CYCLES < 1 || DELAY_UNIT_CYCLES >= (1 << ldo_pkg::PRESC_W)) begin : g_bad_unit
		$error("DELAY_UNIT_CYCLES out of range");
	end

	// The longest turn-on wait must fit the per-channel unit counter
	if ((1 << ((1 << ldo_pkg::DELAY_W) - 2)) > 255) begin : g_bad_delay
		$error("Delay field too wide for the wait counter");
	end

	// ------------------------------------------------------------
	// Reset release
	// ------------------------------------------------------------
	logic rst_s1;
	logic rst_s2;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_s1 <= 1'b0;
			rst_s2 <= 1'b0;
		end else begin
			rst_s1 <= 1'b1;
			rst_s2 <= rst_s1;
		end
	end

	// ------------------------------------------------------------
	// Comparator input synchronisers
	// ------------------------------------------------------------
	logic [ldo_pkg::NUM_CH-1:0] good_s1;
	logic [ldo_pkg::NUM_CH-1:0] good_s2;

	always_ff @(posedge clk or negedge rst_s2) begin
		if (!rst_s2) begin
			good_s1 <= '0;
			good_s2 <= '0;
		end else begin
			good_s1 <= out_above_threshold;
			good_s2 <= good_s1;
		end
	end

	// ------------------------------------------------------------
	// Shared 2 ms tick
	// ------------------------------------------------------------
	logic [ldo_pkg::PRESC_W-1:0] presc;
	logic [ldo_pkg::PRESC_W-1:0] next_presc;
	logic tick;
	logic next_tick;

	always_comb begin
		next_tick = 1'b0;
		next_presc = presc + 1'b1;
		if (presc == ldo_pkg::PRESC_W'(DELAY_UNIT_CYCLES - 1)) begin
			next_presc = '0;
			next_tick = 1'b1;
		end
	end

	always_ff @(posedge clk or negedge rst_s2) begin
		if (!rst_s2) begin
			presc <= '0;
			tick <= 1'b0;
		end else begin
			presc <= next_presc;
			tick <= next_tick;
		end
	end

	// ------------------------------------------------------------
	// Channels
	// ------------------------------------------------------------
	logic [ldo_pkg::NUM_CH-1:0] pend;

	// One identical slice per channel
	for (genvar ch = 0; ch < ldo_pkg::NUM_CH; ch++) begin : g_ch
		ldo_pkg::ldo_state_t state;
		ldo_pkg::ldo_state_t next_state;
		logic en_prev;
		logic next_en_prev;
		logic [7:0] wait_cnt;
		logic [7:0] next_wait_cnt;
		logic [ldo_pkg::CODE_W-1:0] code;
		logic [ldo_pkg::CODE_W-1:0] next_code;
		logic fault;
		logic next_fault;
		logic read_seen;
		logic next_read_seen;
		logic rise_seen;
		logic fall_seen;
		logic good_now;
		ldo_pkg::ldo_drive_t next_drive;
		logic next_pg;
		logic next_on;

		// ------------------------------------------------------------
		// Enable edges and power state
		// ------------------------------------------------------------
		// Only transitions of the enable bit act, never its level
		assign rise_seen = ctrl[ch].enable && !en_prev;
		assign fall_seen = !ctrl[ch].enable && en_prev;

		always_comb begin
			next_state = state;
			next_en_prev = ctrl[ch].enable;
			next_wait_cnt = wait_cnt;
			unique case (state)
				ldo_pkg::LDO_OFF: begin
					if (rise_seen) begin
						// 0 ms, else 2**(code-1) units of 2 ms
						if (ctrl[ch].delay_code == 3'h0) begin
							next_state = ldo_pkg::LDO_ON;
						end else begin
							next_state = ldo_pkg::LDO_WAIT;
							next_wait_cnt = 8'(1) << (ctrl[ch].delay_code - 3'h1);
						end
					end
				end
				ldo_pkg::LDO_WAIT: begin
					if (fall_seen) begin
						next_state = ldo_pkg::LDO_OFF;
					end else if (tick) begin
						if (wait_cnt == 8'h01) begin
							next_state = ldo_pkg::LDO_ON;
						end
						next_wait_cnt = wait_cnt - 8'h01;
					end
				end
				ldo_pkg::LDO_ON: begin
					if (fall_seen) begin
						next_state = ldo_pkg::LDO_OFF;
					end
				end
			endcase
		end

		always_ff @(posedge clk or negedge rst_s2) begin
			if (!rst_s2) begin
				state <= ldo_pkg::LDO_OFF;
				en_prev <= 1'b0;
				wait_cnt <= ldo_pkg::WAIT_CNT_RESET;
			end else begin
				state <= next_state;
				en_prev <= next_en_prev;
				wait_cnt <= next_wait_cnt;
			end
		end

		// ------------------------------------------------------------
		// Voltage code
		// ------------------------------------------------------------
		always_comb begin
			next_code = code;
			if (code_write[ch]) begin
				next_code = code_wdata;
			end
		end

		always_ff @(posedge clk or negedge rst_s2) begin
			if (!rst_s2) begin
				code <= ldo_pkg::CODE_RESET;
			end else begin
				code <= next_code;
			end
		end

		// ------------------------------------------------------------
		// Fault capture
		// ------------------------------------------------------------
		// Good only counts while the channel regulates
		assign good_now = (state == ldo_pkg::LDO_ON) && good_s2[ch];

		always_comb begin
			next_fault = fault;
			next_read_seen = read_seen;
			// A read may come before recovery, so it is remembered
			if (fault && pg_read[ch]) begin
				next_read_seen = 1'b1;
			end
			if (fault && read_seen && (good_now || state != ldo_pkg::LDO_ON)) begin
				next_fault = 1'b0;
				next_read_seen = 1'b0;
			end
			// Set wins over clear
			if (ctrl[ch].fault_irq_enable && state == ldo_pkg::LDO_ON && !good_s2[ch]) begin
				next_fault = 1'b1;
			end
			if (!next_fault) begin
				next_read_seen = 1'b0;
			end
		end

		always_ff @(posedge clk or negedge rst_s2) begin
			if (!rst_s2) begin
				fault <= 1'b0;
				read_seen <= 1'b0;
			end else begin
				fault <= next_fault;
				read_seen <= next_read_seen;
			end
		end

		assign pend[ch] = next_fault;

		// ------------------------------------------------------------
		// Registered outputs
		// ------------------------------------------------------------
		always_comb begin
			next_drive.regulate = (next_state == ldo_pkg::LDO_ON);
			next_drive.discharge_on = (next_state != ldo_pkg::LDO_ON) && ctrl[ch].discharge_enable;
			next_drive.low_power = ctrl[ch].low_quiescent_select;
			next_drive.output_voltage_code = next_code;
			next_pg = good_now;
			next_on = (next_state == ldo_pkg::LDO_ON);
		end

		always_ff @(posedge clk or negedge rst_s2) begin
			if (!rst_s2) begin
				drive[ch] <= '0;
				power_good_flag[ch] <= 1'b0;
				channel_on[ch] <= 1'b0;
			end else begin
				drive[ch] <= next_drive;
				power_good_flag[ch] <= next_pg;
				channel_on[ch] <= next_on;
			end
		end
	end

	// ------------------------------------------------------------
	// Interrupt
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_s2) begin
		if (!rst_s2) begin
			interrupt_request_n <= 1'b1;
		end else begin
			interrupt_request_n <= ~(|pend);
		end
	end

endmodule // ldo_channel_control

/* rtl/ldo_pkg.sv */
// Package of constants and types for the linear regulator channel controller
package ldo_pkg;

	// ------------------------------------------------------------
	// Geometry
	// ------------------------------------------------------------
	localparam int NUM_CH = 4;
	localparam int CODE_W = 6;
	localparam int DELAY_W = 3;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int CLK_HZ = 25000000;
	localparam int DELAY_UNIT_MS = 2;
	localparam int DELAY_UNIT_CYC = (CLK_HZ / 1000) * DELAY_UNIT_MS;
	localparam int PRESC_W = 17;

	// ------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------
	localparam logic [CODE_W-1:0] CODE_RESET = 6'h18;
	localparam logic [DELAY_W-1:0] DELAY_RESET = 3'h0;
	localparam logic [7:0] WAIT_CNT_RESET = 8'h00;

	// Voltage code fields: range in the upper half, step in the lower half
	localparam int CODE_RANGE_LSB = 3;
	localparam int CODE_STEP_W = 3;

	// Channel power state
	typedef enum logic [1:0] {
		LDO_OFF,
		LDO_WAIT,
		LDO_ON
	} ldo_state_t;

	// Per-channel control bits from the host side
	typedef struct packed {
		logic enable;
		logic [DELAY_W-1:0] delay_code;
		logic discharge_enable;
		logic low_quiescent_select;
		logic fault_irq_enable;
	} ldo_ctrl_t;

	// Per-channel drive to the analog regulator
	typedef struct packed {
		logic regulate;
		logic discharge_on;
		logic low_power;
		logic [CODE_W-1:0] output_voltage_code;
	} ldo_drive_t;

endpackage

/* tb/ldo_ana_model.sv */
// Regulator outputs seen through their power-good comparators
`timescale 1ns/1ps
module ldo_ana_model (
	input wire ldo_pkg::ldo_drive_t [3:0] drive,
	input wire logic [3:0] sag,
	output logic [3:0] out_above_threshold
);
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			out_above_threshold[i] = drive[i].regulate && !sag[i];
		end
	end
endmodule // ldo_ana_model

/* tb/ldo_chk.sv */
// Port assertions for the linear regulator controller
`timescale 1ns/1ps
module ldo_chk (
	input wire logic clk,
	input wire logic rst_n,
	input wire ldo_pkg::ldo_ctrl_t [3:0] ctrl,
	input wire logic [3:0] code_write,
	input wire logic [5:0] code_wdata,
	input wire logic [3:0] pg_read,
	input wire logic [3:0] out_above_threshold,
	input wire ldo_pkg::ldo_drive_t [3:0] drive,
	input wire logic [3:0] power_good_flag,
	input wire logic [3:0] channel_on,
	input wire logic interrupt_request_n
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	wire any_mask = ctrl[0].fault_irq_enable | ctrl[1].fault_irq_enable | ctrl[2].fault_irq_enable
		| ctrl[3].fault_irq_enable;
	sequence fault_held;
		(channel_on[0] && ctrl[0].fault_irq_enable && !out_above_threshold[0])[*6];
	endsequence
	turn_on_a: assert property ($rose(ctrl[0].enable) && ctrl[0].delay_code == 3'h0 && !channel_on[0]
		|-> ##[1:2] channel_on[0]) else $error("no turn on");
	turn_off_a: assert property ($fell(ctrl[0].enable) |-> ##[1:2] !channel_on[0]) else $error("no turn off");
	on_drive_a: assert property (channel_on[0] |-> drive[0].regulate && !drive[0].discharge_on)
		else $error("drive wrong while on");
	discharge_a: assert property ((!channel_on[0] && ctrl[0].discharge_enable && !ctrl[0].enable)[*5]
		|-> drive[0].discharge_on) else $error("no discharge");
	low_power_a: assert property (ctrl[0].low_quiescent_select[*2] |-> drive[0].low_power)
		else $error("no low power");
	code_load_a: assert property (code_write[1] |=> drive[1].output_voltage_code == $past(code_wdata))
		else $error("code not loaded");
	fault_irq_a: assert property (fault_held |-> !interrupt_request_n) else $error("no interrupt");
	irq_masked_a: assert property (interrupt_request_n && !any_mask |=> interrupt_request_n)
		else $error("masked interrupt");
endmodule // ldo_chk
bind ldo_channel_control ldo_chk u_chk (.clk(clk), .rst_n(rst_n), .ctrl(ctrl), .code_write(code_write),
	.code_wdata(code_wdata), .pg_read(pg_read), .out_above_threshold(out_above_threshold), .drive(drive),
	.power_good_flag(power_good_flag), .channel_on(channel_on), .interrupt_request_n(interrupt_request_n));

/* tb/tb.sv */
// Self-checking bench for the linear regulator controller
`timescale 1ns/1ps
module tb;
	logic clk = 0;
	logic rst_n = 0;
	ldo_pkg::ldo_ctrl_t [3:0] ctrl = '0;
	logic [3:0] cw = 0, pr = 0, sag = 0, oat, pg, on;
	logic [5:0] cd = 0;
	ldo_pkg::ldo_drive_t [3:0] drv;
	logic irq_n;
	int num_errors = 0, n_checks = 0, cyc = 0;
	always #20 clk = ~clk;
	ldo_channel_control #(.DELAY_UNIT_CYCLES(4)) i_dut (.clk(clk), .rst_n(rst_n), .ctrl(ctrl), .code_write(cw),
		.code_wdata(cd), .pg_read(pr), .out_above_threshold(oat), .drive(drv), .power_good_flag(pg),
		.channel_on(on), .interrupt_request_n(irq_n));
	ldo_ana_model i_ana (.drive(drv), .sag(sag), .out_above_threshold(oat));
	task automatic tk(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic chk(input string s, input logic [5:0] e, input logic [5:0] g);
		n_checks++;
		if (g !== e) begin
			num_errors++;
			$display("ERROR %s exp %h got %h", s, e, g);
		end
	endtask
	task automatic en(input int c, input logic v);
		ctrl[c].enable = v;
		tk(1);
	endtask
	task automatic rd(input int c);
		pr[c] = 1;
		tk(1);
		pr = 0;
	endtask
	task automatic final_report;
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 2000) begin
			num_errors++;
			final_report;
		end
	end
	initial begin
		for (int c = 0; c < 4; c++) ctrl[c].discharge_enable = 1;
		tk(2);
		rst_n = 1;
		tk(3);
		for (int c = 0; c < 4; c++) begin
			chk("code", 6'h18, drv[c].output_voltage_code);
			chk("dis", 1, drv[c].discharge_on);
			en(c, 1);
			tk(2);
			chk("on", 1, on[c]);
			chk("dis", 0, drv[c].discharge_on);
		end
		$display("power-up done");
		for (int i = 0; i < 3; i++) begin
			cd = 6'h3F >> (i * 3);
			cw[1] = 1;
			tk(1);
			cw = 0;
			tk(1);
			chk("code", cd, drv[1].output_voltage_code);
		end
		chk("code", 6'h18, drv[2].output_voltage_code);
		$display("code done");
		for (int k = 2; k < 5; k++) begin
			en(1, 0);
			tk(2);
			chk("off", 0, on[1]);
			chk("dis", 1, drv[1].discharge_on);
			ctrl[1].delay_code = 3'(k);
			en(1, 1);
			tk(((1 << (k - 1)) - 1) * 4 - 2);
			chk("wait", 0, on[1]);
			tk(12);
			chk("on", 1, on[1]);
		end
		$display("delay done");
		ctrl[2].low_quiescent_select = 1;
		tk(3);
		chk("lowq", 1, drv[2].low_power);
		chk("lowq", 0, drv[3].low_power);
		ctrl[0].fault_irq_enable = 1;
		sag[3] = 1;
		tk(8);
		chk("irq", 1, irq_n);
		chk("pg", 0, pg[3]);
		sag = 4'h1;
		tk(8);
		chk("irq", 0, irq_n);
		sag = 0;
		tk(8);
		chk("pg", 1, pg[0]);
		chk("irq", 0, irq_n);
		rd(0);
		tk(4);
		chk("irq", 1, irq_n);
		sag = 4'h1;
		tk(8);
		rd(0);
		tk(4);
		chk("irq", 0, irq_n);
		en(0, 0);
		tk(4);
		chk("irq", 1, irq_n);
		$display("fault done");
		final_report;
	end
endmodule // tb
